// >>> src/pwr_pkg.sv
// Package for the port three reference-compare wake block.
// Assumes a 12-bit linear register address and 8-bit register data.
package pwr_pkg;
   // Register addresses on the linear register bus
   localparam logic [11:0] ADDR_WAKE_STATUS = 12'hF0A;
   localparam logic [11:0] ADDR_PIN_SELECT  = 12'hF0E;
   localparam logic [11:0] ADDR_PORT_THREE  = 12'h003;

   // Field positions in the status and enable register, then field, select and bus widths
   localparam int IRQ_EN_BIT          = 4;
   localparam int PORT_THREE_STAT_LSB = 2;
   localparam int PORT_TWO_STAT_LSB   = 0;
   localparam int STAT_WIDTH          = 2;
   localparam int SEL_WIDTH           = 4;
   localparam int DATA_WIDTH          = 8;
   localparam int ADDR_WIDTH          = 12;

   // Reference status codes
   localparam logic [1:0] STAT_NONE  = 2'h0;
   localparam logic [1:0] STAT_READ  = 2'h1;
   localparam logic [1:0] STAT_WRITE = 2'h2;

   // Values after reset
   localparam logic [3:0] SEL_RESET  = 4'h0;
   localparam logic [3:0] REF_RESET  = 4'h0;
   localparam logic [7:0] DATA_RESET = 8'h00;
endpackage

// >>> src/pwr_ref_if.sv
// Interface between the wake top and its reference latch.
// Assumes a single clock domain shared by both ends.
`timescale 1ns/1ns
`default_nettype none
interface pwr_ref_if;
   logic       accRead;    // Port three data read this cycle
   logic       accWrite;   // Port three data write this cycle
   logic       armed;      // At least one pin selected
   logic [3:0] wrNibble;   // Written value, low nibble
   logic [3:0] pinNibble;  // Sampled pins
   logic       swWrite;    // Software writes the status field
   logic [1:0] swStatus;   // Value software writes
   logic [1:0] status;     // Reference status code
   logic [3:0] refBits;    // Latched reference

   modport latch (input accRead, accWrite, armed, wrNibble, pinNibble, swWrite, swStatus,
                  output status, refBits);
   modport user (output accRead, accWrite, armed, wrNibble, pinNibble, swWrite, swStatus,
                 input status, refBits);
endinterface
`default_nettype wire

// >>> src/pwr_pin_compare.sv
// One pin's wake compare: zero-level wake or mismatch against a reference.
// Assumes the pin is already synchronous to the clock.
`timescale 1ns/1ns
`default_nettype none
module pwr_pin_compare (
   input  wire logic pin,
   input  wire logic refBit,
   input  wire logic refActive,
   input  wire logic select,
   output logic      wakeEvent
);
   // Default wakes on a low level; a latched reference wakes on any difference
   always_comb begin
      wakeEvent = select & (refActive ? (pin ^ refBit) : ~pin);
   end
endmodule
`default_nettype wire

// >>> src/pwr_ref_latch.sv
// Reference latch and port three status field.
// Assumes accesses arrive as one-cycle strobes from the register decode.
`timescale 1ns/1ns
`default_nettype none
module pwr_ref_latch (
   input  wire logic clock,
   input  wire logic arst_n,
   pwr_ref_if.latch  ref_port
);
   // Reference follows the last data access once armed; hardware wins over software
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ref_port.refBits <= pwr_pkg::REF_RESET;
         ref_port.status  <= pwr_pkg::STAT_NONE;
      end else if (ref_port.accRead && ref_port.armed) begin
         ref_port.refBits <= ref_port.pinNibble;
         ref_port.status  <= pwr_pkg::STAT_READ;
      end else if (ref_port.accWrite && ref_port.armed) begin
         ref_port.refBits <= ref_port.wrNibble;
         ref_port.status  <= pwr_pkg::STAT_WRITE;
      end else if (ref_port.swWrite) begin
         ref_port.status  <= ref_port.swStatus;
      end
   end
endmodule
`default_nettype wire

// >>> src/pwr_port_wake.sv
// Top of the port three reference-compare wake block with its registers.
// Assumes a plain register port with one-cycle strobes and pins synchronous to clock.
`timescale 1ns/1ns
`default_nettype none
module pwr_port_wake (
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic [11:0] regAddr,
   input  wire logic [7:0]  regWrData,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output logic      [7:0]  regRdData,
   input  wire logic [3:0]  portThreePins,
   input  wire logic        portThreeModeBit1,
   input  wire logic        portTwoReadSeen,
   input  wire logic        portTwoWriteSeen,
   input  wire logic        otherWake,
   output logic      [3:0]  portThreeOut,
   output logic             stopRecovery,
   output logic             interruptLineOne
);
   logic [3:0] pinSelect;
   logic       irqEnable;
   logic [1:0] portTwoStatus;
   logic [3:0] pinEvent;
   logic       anyWake;
   logic       hitStatus;
   logic       hitSelect;
   logic       hitPort;

   pwr_ref_if refBus ();

   // Address decode
   assign hitStatus = (regAddr == pwr_pkg::ADDR_WAKE_STATUS);
   assign hitSelect = (regAddr == pwr_pkg::ADDR_PIN_SELECT);
   assign hitPort   = (regAddr == pwr_pkg::ADDR_PORT_THREE);

   // Requests toward the reference latch
   assign refBus.accRead   = regRead & hitPort;
   assign refBus.accWrite  = regWrite & hitPort;
   assign refBus.armed     = |pinSelect;
   assign refBus.wrNibble  = regWrData[3:0];
   assign refBus.pinNibble = portThreePins;
   assign refBus.swWrite   = regWrite & hitStatus;
   assign refBus.swStatus  = regWrData[pwr_pkg::PORT_THREE_STAT_LSB +: pwr_pkg::STAT_WIDTH];

   pwr_ref_latch u_pwr_ref_latch (
      .clock    (clock),
      .arst_n   (arst_n),
      .ref_port (refBus.latch)
   );

   // Pin select; upper bits are not stored, so their written value does not matter
   // Only the async reset or a write of zero clears it: no stop-recovery reset path exists
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pinSelect <= pwr_pkg::SEL_RESET;
      end else if (regWrite && hitSelect) begin
         pinSelect <= regWrData[3:0];
      end
   end

   // Interrupt enable bit of the status register
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         irqEnable <= 1'b0;
      end else if (regWrite && hitStatus) begin
         irqEnable <= regWrData[pwr_pkg::IRQ_EN_BIT];
      end
   end

   // Port two status; a seen access beats a software write in the same cycle
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         portTwoStatus <= pwr_pkg::STAT_NONE;
      end else if (portTwoReadSeen) begin
         portTwoStatus <= pwr_pkg::STAT_READ;
      end else if (portTwoWriteSeen) begin
         portTwoStatus <= pwr_pkg::STAT_WRITE;
      end else if (regWrite && hitStatus) begin
         portTwoStatus <= regWrData[pwr_pkg::PORT_TWO_STAT_LSB +: pwr_pkg::STAT_WIDTH];
      end
   end

   // Port three output latch written by software
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         portThreeOut <= pwr_pkg::REF_RESET;
      end else if (regWrite && hitPort) begin
         portThreeOut <= regWrData[3:0];
      end
   end

   // One compare per pin
   for (genvar n = 0; n < pwr_pkg::SEL_WIDTH; n++) begin : g_pin
      pwr_pin_compare u_pwr_pin_compare (
         .pin       (portThreePins[n]),
         .refBit    (refBus.refBits[n]),
         .refActive (refBus.status != pwr_pkg::STAT_NONE),
         .select    (pinSelect[n]),
         .wakeEvent (pinEvent[n])
      );
   end

   assign anyWake = (|pinEvent) | otherWake;

   // Wake level is registered so the output is glitch free
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         stopRecovery <= 1'b0;
      end else begin
         stopRecovery <= anyWake;
      end
   end

   // Interrupt follows wake only while one of the two enables is set
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         interruptLineOne <= 1'b0;
      end else begin
         interruptLineOne <= anyWake & (irqEnable | portThreeModeBit1);
      end
   end

   // Read data one cycle after the strobe; select reads as zero, unmapped reads as zero
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         regRdData <= pwr_pkg::DATA_RESET;
      end else if (regRead && hitStatus) begin
         regRdData <= {3'h0, irqEnable, refBus.status, portTwoStatus};
      end else if (regRead && hitPort) begin
         regRdData <= {4'h0, portThreePins};
      end else begin
         regRdData <= pwr_pkg::DATA_RESET;
      end
   end

   // Checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);

   chk_select_write: assert property (
      regWrite && hitSelect |=> pinSelect == $past(regWrData[3:0]))
      else $error("pin select not loaded");
   chk_unselected_quiet: assert property (
      pinSelect == 4'h0 && !otherWake |=> !stopRecovery)
      else $error("wake with no source selected");
   chk_default_low: assert property (
      refBus.status == pwr_pkg::STAT_NONE && pinSelect[0] && !portThreePins[0] |=> stopRecovery)
      else $error("low pin did not wake");
   chk_ref_mismatch: assert property (
      refBus.status != pwr_pkg::STAT_NONE && |(pinSelect & (portThreePins ^ refBus.refBits))
      |=> stopRecovery)
      else $error("reference mismatch did not wake");
   chk_read_status: assert property (
      refBus.accRead && refBus.armed |=> refBus.status == pwr_pkg::STAT_READ
      && refBus.refBits == $past(portThreePins))
      else $error("read did not latch reference");
   chk_write_status: assert property (
      refBus.accWrite && refBus.armed |=> refBus.status == pwr_pkg::STAT_WRITE
      && refBus.refBits == $past(regWrData[3:0]))
      else $error("write did not latch reference");
   // An unselected port must not pick up a stale reference from ordinary traffic
   chk_unarmed_hold: assert property (
      !refBus.armed && !refBus.swWrite |=> $stable(refBus.status) && $stable(refBus.refBits))
      else $error("reference moved while no pin selected");
   chk_select_kept: assert property (
      !(regWrite && hitSelect) |=> $stable(pinSelect))
      else $error("pin select changed without a write");
   chk_sw_clear: assert property (
      regWrite && hitStatus && regWrData[3:2] == 2'h0 |=> refBus.status == pwr_pkg::STAT_NONE)
      else $error("status clear lost");
   chk_port_two: assert property (
      portTwoReadSeen |=> portTwoStatus == pwr_pkg::STAT_READ)
      else $error("port two read not recorded");
   chk_irq_enabled: assert property (
      irqEnable && anyWake |=> interruptLineOne && stopRecovery)
      else $error("interrupt missing");
   chk_irq_blocked: assert property (
      !irqEnable && !portThreeModeBit1 |=> !interruptLineOne)
      else $error("interrupt while disabled");
   chk_status_read: assert property (
      regRead && hitStatus |=> regRdData[7:5] == 3'h0
      && regRdData[4] == $past(irqEnable)
      && regRdData[3:2] == $past(refBus.status)
      && regRdData[1:0] == $past(portTwoStatus))
      else $error("status read wrong");
   chk_any_source: assert property (
      otherWake |=> stopRecovery)
      else $error("other wake source ignored");

   cov_read_ref_wake: cover property (
      refBus.status == pwr_pkg::STAT_READ ##1 stopRecovery);
   cov_write_ref_wake: cover property (
      refBus.status == pwr_pkg::STAT_WRITE ##1 interruptLineOne);
   cov_clear_back: cover property (
      refBus.status != pwr_pkg::STAT_NONE ##1 refBus.status == pwr_pkg::STAT_NONE);
   cov_mode_irq: cover property (
      !irqEnable && portThreeModeBit1 ##1 interruptLineOne);
endmodule
`default_nettype wire

// >>> dv/pwr_pin_model.sv
// Behavioural model of the port three pins and port two strobes outside the block.
// Assumes the bench asks for levels and pulses just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module pwr_pin_model (
   input  wire logic       clock,
   input  wire logic [3:0] wantPins,
   input  wire logic       wantTwoRead,
   input  wire logic       wantTwoWrite,
   output logic      [3:0] pins,
   output logic            twoRead,
   output logic            twoWrite
);
   // Pins settle on a rising edge, so the block always sees a synchronous level
   always_ff @(posedge clock) begin
      pins <= wantPins;
   end
   // Port two strobes last one cycle; a read wins so both never arrive together
   always_ff @(posedge clock) begin
      twoRead  <= wantTwoRead;
      twoWrite <= wantTwoWrite & ~wantTwoRead;
   end
endmodule
`default_nettype wire

// >>> dv/pwr_port_wake_tb_top.sv
// Self-checking bench for the port three reference-compare wake block.
// Assumes the plain register port and one-cycle-late wake outputs.
`timescale 1ns/1ns
`default_nettype none
module pwr_port_wake_tb_top;
   logic        clock = 1'b0;
   logic        arst_n = 1'b0;
   logic [11:0] regAddr = 12'h000;
   logic [7:0]  regWrData = 8'h00;
   logic        regWrite = 1'b0;
   logic        regRead = 1'b0;
   logic [7:0]  regRdData;
   logic [3:0]  wantPins = 4'hF;
   logic [3:0]  pins;
   logic        modeBit1 = 1'b0;
   logic        wantTwoRead = 1'b0;
   logic        wantTwoWrite = 1'b0;
   logic        twoRead;
   logic        twoWrite;
   logic        otherWake = 1'b0;
   logic [3:0]  portThreeOut;
   logic        stopRecovery;
   logic        interruptLineOne;
   int          n_errors = 0;
   int          samples_checked = 0;

   // Free-running 100 MHz clock
   always #5 clock = ~clock;

   pwr_pin_model u_pwr_pin_model (.clock(clock), .wantPins(wantPins), .wantTwoRead(wantTwoRead),
      .wantTwoWrite(wantTwoWrite), .pins(pins), .twoRead(twoRead), .twoWrite(twoWrite));

   pwr_port_wake u_pwr_port_wake (.clock(clock), .arst_n(arst_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .portThreePins(pins), .portThreeModeBit1(modeBit1), .portTwoReadSeen(twoRead),
      .portTwoWriteSeen(twoWrite), .otherWake(otherWake), .portThreeOut(portThreeOut),
      .stopRecovery(stopRecovery), .interruptLineOne(interruptLineOne));

   // One comparison with its own mismatch line
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Single-cycle write strobe
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clock);
      regAddr   <= a;
      regWrData <= d;
      regWrite  <= 1'b1;
      @(posedge clock);
      regWrite  <= 1'b0;
   endtask

   // Single-cycle read; data stand only in the following cycle
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1;
      cmp(regRdData, exp);
   endtask

   // Pins pass the model and the wake register, so three edges is settled
   task automatic wake(input logic [3:0] p, input logic sr, input logic irq);
      @(posedge clock);
      wantPins <= p;
      repeat (3) @(posedge clock);
      #1;
      cmp({6'h00, stopRecovery, interruptLineOne}, {6'h00, sr, irq});
   endtask

   // One-cycle pulse on a port two strobe through the model
   task automatic twoPulse(input logic isRead);
      @(posedge clock);
      wantTwoRead  <= isRead;
      wantTwoWrite <= ~isRead;
      @(posedge clock);
      wantTwoRead  <= 1'b0;
      wantTwoWrite <= 1'b0;
      repeat (2) @(posedge clock);
   endtask

   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Watchdog: a hang counts as a mismatch and goes to the report
   initial begin
      repeat (5000) @(posedge clock);
      n_errors++;
      tally_and_finish();
   end

   // Main sequence
   initial begin
      repeat (6) @(posedge clock);
      arst_n <= 1'b1;
      rd(12'hF0A, 8'h00);
      rd(12'hF0E, 8'h00);
      rd(12'h123, 8'h00);
      wake(4'h0, 1'b0, 1'b0);
      otherWake <= 1'b1;
      wake(4'h0, 1'b1, 1'b0);
      otherWake <= 1'b0;
      wr(12'hF0E, 8'hF1);
      rd(12'hF0E, 8'h00);
      wake(4'hE, 1'b1, 1'b0);
      wake(4'h1, 1'b0, 1'b0);
      wr(12'h003, 8'h50);
      #1;
      cmp({4'h0, portThreeOut}, 8'h00);
      rd(12'hF0A, 8'h08);
      wake(4'h1, 1'b1, 1'b0);
      wake(4'hE, 1'b0, 1'b0);
      wake(4'h1, 1'b1, 1'b0);
      rd(12'h003, 8'h01);
      rd(12'hF0A, 8'h04);
      wake(4'h0, 1'b1, 1'b0);
      wake(4'h1, 1'b0, 1'b0);
      wr(12'hF0A, 8'h00);
      wake(4'h1, 1'b0, 1'b0);
      wake(4'h0, 1'b1, 1'b0);
      modeBit1 <= 1'b1;
      wake(4'h0, 1'b1, 1'b1);
      modeBit1 <= 1'b0;
      wr(12'hF0A, 8'h10);
      rd(12'hF0A, 8'h10);
      wake(4'h0, 1'b1, 1'b1);
      wake(4'h1, 1'b0, 1'b0);
      twoPulse(1'b1);
      rd(12'hF0A, 8'h11);
      twoPulse(1'b0);
      rd(12'hF0A, 8'h12);
      wake(4'h0, 1'b1, 1'b1);
      rd(12'hF0A, 8'h12);
      wake(4'h1, 1'b0, 1'b0);
      // Unmapped write must leave every register alone
      wr(12'h123, 8'hFF);
      rd(12'hF0A, 8'h12);
      // Non-zero reference so the output latch and per-bit compare are really exercised
      wr(12'h003, 8'hA5);
      #1;
      cmp({4'h0, portThreeOut}, 8'h05);
      rd(12'hF0A, 8'h1A);
      // Read data stand one cycle only, then fall back to zero
      @(posedge clock);
      #1;
      cmp(regRdData, 8'h00);
      wake(4'h1, 1'b0, 1'b0);
      wake(4'h0, 1'b1, 1'b1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
